// *** core/ppr_regulator.sv ***
// process pid regulator: set point and measured value to frequency command
// assumes synchronous inputs, avalon-mm master and one 20 MHz clock
//
// The implementer's own choices: the address map and register access over Avalon-MM.
`timescale 1ns/10ps
`include "ppr_regs.svh"

module ppr_regulator #(
  parameter int PERIOD_CYC = `PPR_PERIOD_CYC
) (
  input  wire logic                     clk_in,
  input  wire logic                     rst_in,
  input  wire ppr_pkg::ppr_bus_req_type bus_in,
  output      ppr_pkg::ppr_bus_rsp_type bus_out,
  input  wire ppr_pkg::ppr_analog_type  analog_in,
  input  wire ppr_pkg::ppr_run_type     run_in,
  input  wire logic [6:0]               terminal_in,
  output      logic [2:0]               terminal_out,
  output      logic                     irq_out
);
  import ppr_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                bus_ack;
    logic [31:0]         rdata;
    logic                net_sel;
    logic                action_fwd;
    logic [1:0]          set_range;
    logic [1:0]          meas_range;
    logic [7:0]          mode;
    logic [15:0]         set_pt;
    logic [15:0]         up_lim;
    logic [15:0]         lo_lim;
    logic [15:0]         gain;
    logic [15:0]         integ;
    logic [15:0]         deriv;
    logic [55:0]         in_func;
    logic [23:0]         out_func;
    logic [15:0]         net_set;
    logic [15:0]         net_meas;
    logic signed [16:0]  net_dev;
    logic [15:0]         period;
    logic signed [16:0]  dev;
    logic signed [16:0]  dev_prev;
    logic signed [31:0]  acc;
    logic signed [31:0]  mv;
    logic                upper_limit_flag;
    logic                lower_limit_flag;
    logic                active;
    logic [3:0]          irq_stat;
    logic [3:0]          irq_mask;
    logic [2:0]          term;
    logic                irq;
  } ppr_state_type;

  ppr_state_type state_reg;
  ppr_state_type state_next;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // raw converter code to tenths of a percent
  function automatic logic [15:0] scale(input logic [11:0] raw, input logic [11:0] zero);
    logic [23:0] span;
    span = 24'(raw > zero ? raw - zero : 12'h000) * 24'(`PPR_FULL_SCALE);
    return 16'(span / 24'(`PPR_ADC_MAX - zero));
  endfunction

  function automatic logic is_pid_mode(input logic [7:0] m);
    return m == 8'd20 || m == 8'd21 || m == 8'd50 || m == 8'd51
        || m == 8'd60 || m == 8'd61;
  endfunction

  function automatic logic [31:0] word(input logic [15:0] v);
    return {16'h0000, v};
  endfunction

  logic              sel_assigned;
  logic              sel_level;
  logic              pid_on;
  logic [15:0]       set_pct;
  logic [15:0]       meas_pct;
  logic signed [16:0] dev_new;
  logic [3:0]        events;

  always_comb begin
    sel_assigned = 1'b0;
    sel_level    = 1'b0;
    for (int i = 0; i < `PPR_INPUTS; i++) begin
      if (state_reg.in_func[i*8 +: 8] == `PPR_SEL_CODE) begin
        sel_assigned = 1'b1;
        sel_level    = sel_level | terminal_in[i];
      end
    end
    sel_level = sel_level | state_reg.net_sel;
    pid_on = is_pid_mode(state_reg.mode) && (!sel_assigned || sel_level);
  end

  always_comb begin
    if (state_reg.mode == 8'd60 || state_reg.mode == 8'd61) begin
      set_pct = state_reg.net_set;
    end else if (state_reg.set_pt == `PPR_NO_FUNC) begin
      // range 1 means 0..5 V: the input full scale is halved
      set_pct = scale(state_reg.set_range[0] ? {analog_in.ain2[10:0], 1'b0} |
                      {12{analog_in.ain2[11]}} : analog_in.ain2, 12'h000);
    end else begin
      set_pct = state_reg.set_pt;
    end
    if (state_reg.mode == 8'd60 || state_reg.mode == 8'd61) begin
      meas_pct = state_reg.net_meas;
    end else if (state_reg.meas_range == 2'd0) begin
      meas_pct = scale(analog_in.ain4, `PPR_ADC_4MA);
    end else if (state_reg.meas_range == 2'd1) begin
      meas_pct = scale({analog_in.ain4[10:0], 1'b0} | {12{analog_in.ain4[11]}}, 12'h000);
    end else begin
      meas_pct = scale(analog_in.ain4, 12'h000);
    end
    if (state_reg.mode == 8'd50 || state_reg.mode == 8'd51) begin
      dev_new = state_reg.net_dev;
    end else begin
      dev_new = $signed({1'b0, set_pct}) - $signed({1'b0, meas_pct});
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic signed [31:0] p_term;
    logic signed [31:0] d_term;
    logic signed [31:0] sum;
    logic               lim_mode;
    p_term     = '0;
    d_term     = '0;
    sum        = '0;
    lim_mode   = 1'b0;
    state_next = state_reg;
    state_next.bus_ack = 1'b0;

    // odd modes run forward action
    state_next.action_fwd = state_reg.mode[0];

    if (state_reg.period == 16'(PERIOD_CYC - 1)) begin
      state_next.period = '0;
      if (pid_on) begin
        state_next.dev      = dev_new;
        state_next.dev_prev = state_reg.dev;
        if (state_reg.integ != `PPR_NO_FUNC && state_reg.integ != 16'h0000) begin
          // signed throughout so a negative deviation winds the integrator down
          state_next.acc = state_reg.acc
                           + (32'(dev_new) * $signed({16'h0000, state_reg.gain}))
                           / $signed({16'h0000, state_reg.integ});
        end
        p_term = 32'(dev_new) * 32'(state_reg.gain);
        if (state_reg.deriv != `PPR_NO_FUNC) begin
          d_term = 32'(dev_new - state_reg.dev) * 32'(state_reg.gain)
                   * 32'(state_reg.deriv);
        end
        sum = p_term + state_next.acc + d_term;
        state_next.mv = state_reg.action_fwd ? -sum : sum;
      end else begin
        state_next.acc = '0;
        state_next.mv  = '0;
      end
    end else begin
      state_next.period = state_reg.period + 16'h0001;
    end

    lim_mode = state_reg.mode == 8'd20 || state_reg.mode == 8'd21
            || state_reg.mode == 8'd60 || state_reg.mode == 8'd61;
    state_next.upper_limit_flag    = lim_mode && state_reg.up_lim != `PPR_NO_FUNC
                        && meas_pct > state_reg.up_lim;
    state_next.lower_limit_flag    = lim_mode && state_reg.lo_lim != `PPR_NO_FUNC
                        && meas_pct < state_reg.lo_lim;
    state_next.active = pid_on;

    for (int j = 0; j < `PPR_OUTPUTS; j++) begin
      logic [7:0] code;
      logic       lvl;
      code = state_reg.out_func[j*8 +: 8];
      lvl  = 1'b0;
      unique case (code >= `PPR_CODE_INV ? code - `PPR_CODE_INV : code)
        `PPR_CODE_FUP: lvl = state_reg.upper_limit_flag;
        `PPR_CODE_FDN: lvl = state_reg.lower_limit_flag;
        `PPR_CODE_DIR: lvl = run_in.forward_rotation && !run_in.reverse_rotation;
        `PPR_CODE_ACT: lvl = state_reg.active;
        default:       lvl = 1'b0;
      endcase
      state_next.term[j] = code >= `PPR_CODE_INV ? !lvl : lvl;
    end

    // events: upper, lower, active rise, active fall
    events = {state_reg.upper_limit_flag & !state_next.upper_limit_flag ? 1'b0 : state_next.upper_limit_flag & !state_reg.upper_limit_flag,
              state_next.lower_limit_flag & !state_reg.lower_limit_flag,
              state_next.active & !state_reg.active,
              state_reg.active & !state_next.active};

    // bus: one wait state, answer on the second edge
    if ((bus_in.read || bus_in.write) && !state_reg.bus_ack) begin
      state_next.bus_ack = 1'b1;
      state_next.rdata   = '0;
      if (bus_in.write) begin
        unique case (bus_in.address)
          `PPR_OFS_CTRL: begin
            state_next.net_sel    = bus_in.writedata[0];
            state_next.set_range  = bus_in.writedata[5:4];
            state_next.meas_range = bus_in.writedata[9:8];
          end
          `PPR_OFS_MODE:     state_next.mode     = bus_in.writedata[7:0];
          `PPR_OFS_SETPT:    state_next.set_pt   = bus_in.writedata[15:0];
          `PPR_OFS_UPLIM:    state_next.up_lim   = bus_in.writedata[15:0];
          `PPR_OFS_LOLIM:    state_next.lo_lim   = bus_in.writedata[15:0];
          `PPR_OFS_GAIN:     state_next.gain     = bus_in.writedata[15:0];
          `PPR_OFS_INTEG:    state_next.integ    = bus_in.writedata[15:0];
          `PPR_OFS_DERIV:    state_next.deriv    = bus_in.writedata[15:0];
          // only the first four terminals are reachable through one word
          `PPR_OFS_INFUNC:   state_next.in_func  = {state_reg.in_func[55:32], bus_in.writedata};
          `PPR_OFS_OUTFUNC:  state_next.out_func = bus_in.writedata[23:0];
          `PPR_OFS_NETSET:   state_next.net_set  = bus_in.writedata[15:0];
          `PPR_OFS_NETMEAS:  state_next.net_meas = bus_in.writedata[15:0];
          `PPR_OFS_NETDEV:   state_next.net_dev  = bus_in.writedata[16:0];
          `PPR_OFS_IRQ_MASK: state_next.irq_mask = bus_in.writedata[3:0];
          default: ;
        endcase
      end else begin
        unique case (bus_in.address)
          `PPR_OFS_CTRL:     state_next.rdata = {22'h000000, state_reg.meas_range, 2'b00,
                                                 state_reg.set_range, 3'b000, state_reg.net_sel};
          `PPR_OFS_MODE:     state_next.rdata = {24'h000000, state_reg.mode};
          `PPR_OFS_SETPT:    state_next.rdata = word(state_reg.set_pt);
          `PPR_OFS_UPLIM:    state_next.rdata = word(state_reg.up_lim);
          `PPR_OFS_LOLIM:    state_next.rdata = word(state_reg.lo_lim);
          `PPR_OFS_GAIN:     state_next.rdata = word(state_reg.gain);
          `PPR_OFS_INTEG:    state_next.rdata = word(state_reg.integ);
          `PPR_OFS_DERIV:    state_next.rdata = word(state_reg.deriv);
          `PPR_OFS_INFUNC:   state_next.rdata = state_reg.in_func[31:0];
          `PPR_OFS_OUTFUNC:  state_next.rdata = {8'h00, state_reg.out_func};
          `PPR_OFS_NETSET:   state_next.rdata = word(state_reg.net_set);
          `PPR_OFS_NETMEAS:  state_next.rdata = word(state_reg.net_meas);
          `PPR_OFS_NETDEV:   state_next.rdata = 32'(state_reg.net_dev);
          `PPR_OFS_STATUS:   state_next.rdata = {28'h0000000, state_reg.active, state_reg.lower_limit_flag,
                                                 state_reg.upper_limit_flag, state_reg.action_fwd};
          `PPR_OFS_IRQ_STAT: state_next.rdata = {28'h0000000, state_reg.irq_stat};
          `PPR_OFS_IRQ_MASK: state_next.rdata = {28'h0000000, state_reg.irq_mask};
          `PPR_OFS_MV:       state_next.rdata = state_reg.mv;
          default:           state_next.rdata = 32'h00000000;
        endcase
      end
    end

    // set wins over a write-one clear in the same cycle
    state_next.irq_stat = state_reg.irq_stat;
    if (bus_in.write && !state_reg.bus_ack && bus_in.address == `PPR_OFS_IRQ_STAT) begin
      state_next.irq_stat = state_reg.irq_stat & ~bus_in.writedata[3:0];
    end
    state_next.irq_stat = state_next.irq_stat | events;
    state_next.irq      = |(state_next.irq_stat & state_next.irq_mask);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg          <= '0;
      state_reg.set_pt   <= `PPR_NO_FUNC;
      state_reg.up_lim   <= `PPR_NO_FUNC;
      state_reg.lo_lim   <= `PPR_NO_FUNC;
      state_reg.integ    <= `PPR_NO_FUNC;
      state_reg.deriv    <= `PPR_NO_FUNC;
      state_reg.gain     <= 16'h0064;
      state_reg.mode     <= 8'h00;
    end else begin
      state_reg <= state_next;
    end
  end

  assign bus_out.readdata    = state_reg.rdata;
  assign bus_out.waitrequest = !state_reg.bus_ack;
  assign terminal_out        = state_reg.term;
  assign irq_out             = state_reg.irq;
endmodule : ppr_regulator

// *** core/ppr_regs.svh ***
// constants for the process pid regulator: offsets, fields, codes, timing
// assumes a 20 MHz clock and avalon-mm word addressing by byte address
//
// What this block does
// - pid runs in modes 20,21,50,51,60,61
// - mode 0 or select off: plain frequency
// - unassigned select input: mode alone enables
// - input function code 14 assigns select
// - reverse: deviation positive raises output
// - forward: deviation negative raises output
// - output is p plus i plus d
// - set point 9999 takes analog input 2
// - set point 0..100% uses panel value
// - measured from input 4, range 0/1/2
// - modes 50/51 take network deviation
// - modes 60/61 take network set/measured
// - upper flag when value exceeds limit, modes 20/21/60/61 only
// - lower flag when value below limit, modes 20/21/60/61 only
// - active output high during regulation
// - codes 100 and up invert terminal
// - network bit may drive select input
`ifndef PPR_REGS_SVH
`define PPR_REGS_SVH

`define PPR_OFS_CTRL      8'h00
`define PPR_OFS_MODE      8'h04
`define PPR_OFS_SETPT     8'h08
`define PPR_OFS_UPLIM     8'h0C
`define PPR_OFS_LOLIM     8'h10
`define PPR_OFS_GAIN      8'h14
`define PPR_OFS_INTEG     8'h18
`define PPR_OFS_DERIV     8'h1C
`define PPR_OFS_INFUNC    8'h20
`define PPR_OFS_OUTFUNC   8'h24
`define PPR_OFS_NETSET    8'h28
`define PPR_OFS_NETMEAS   8'h2C
`define PPR_OFS_NETDEV    8'h30
`define PPR_OFS_STATUS    8'h34
`define PPR_OFS_IRQ_STAT  8'h38
`define PPR_OFS_IRQ_MASK  8'h3C
`define PPR_OFS_MV        8'h40

`define PPR_NO_FUNC       16'd9999
`define PPR_FULL_SCALE    16'd1000
`define PPR_SEL_CODE      8'd14
`define PPR_CODE_FUP      8'd15
`define PPR_CODE_FDN      8'd14
`define PPR_CODE_DIR      8'd16
`define PPR_CODE_ACT      8'd47
`define PPR_CODE_INV      8'd100
`define PPR_INPUTS        7
`define PPR_OUTPUTS       3
`define PPR_PERIOD_US     10
`define PPR_CLK_MHZ       20
`define PPR_PERIOD_CYC    (`PPR_PERIOD_US * `PPR_CLK_MHZ)
`define PPR_ADC_MAX       12'hFFF
`define PPR_ADC_4MA       12'h333

`endif

// *** core/ppr_pkg.sv ***
// types for the process pid regulator
// assumes the constants header is included alongside
package ppr_pkg;
  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [31:0] writedata;
  } ppr_bus_req_type;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } ppr_bus_rsp_type;

  typedef struct packed {
    logic [11:0] ain2;
    logic [11:0] ain4;
  } ppr_analog_type;

  typedef struct packed {
    logic forward_rotation;
    logic reverse_rotation;
  } ppr_run_type;
endpackage : ppr_pkg

// *** bench/ppr_regulator_sva.sv ***
// checker for the regulator bus handshake, reset and status
// assumes bind onto ppr_regulator, one clock domain
`timescale 1ns/10ps
`include "ppr_regs.svh"
module ppr_regulator_sva #(
  parameter int PERIOD_CYC = 4
) (
  input wire logic                     clk_in,
  input wire logic                     rst_in,
  input wire ppr_pkg::ppr_bus_req_type bus_in,
  input wire ppr_pkg::ppr_bus_rsp_type bus_out,
  input wire ppr_pkg::ppr_analog_type  analog_in,
  input wire ppr_pkg::ppr_run_type     run_in,
  input wire logic [6:0]               terminal_in,
  input wire logic [2:0]               terminal_out,
  input wire logic                     irq_out
);
  import ppr_pkg::*;
  // ----
  // shadows
  // ----
  logic       req;
  logic       ack;
  logic       st_rd;
  logic       on;
  logic       mask_reg;
  logic [7:0] mode_reg;
  logic [7:0] age_reg;
  assign req = bus_in.read || bus_in.write;
  assign ack = !bus_out.waitrequest;
  assign st_rd = ack && bus_in.read && bus_in.address == `PPR_OFS_STATUS;
  assign on = mode_reg inside {8'd20, 8'd21, 8'd50, 8'd51, 8'd60, 8'd61};
  // status lags a mode write by one cycle; age stays 0 until a mode is written
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mask_reg <= 1'b0;
      mode_reg <= 8'h00;
      age_reg  <= 8'h00;
    end else begin
      // the design commits a write at the taking edge, one before the answer
      if (!ack && bus_in.write && bus_in.address == `PPR_OFS_IRQ_MASK) begin
        mask_reg <= |bus_in.writedata[3:0];
      end
      if (!ack && bus_in.write && bus_in.address == `PPR_OFS_MODE) begin
        mode_reg <= bus_in.writedata[7:0];
        age_reg  <= 8'h01;
      end else if (age_reg != 8'h00 && age_reg != 8'hFF) begin
        age_reg <= age_reg + 8'h01;
      end
    end
  end
  // ----
  // properties
  // ----
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence ack_s;
    ack;
  endsequence
  ack_once_a: assert property (ack_s |=> !ack)
    else $error("waitrequest low longer than one cycle");
  ack_soon_a: assert property ((req && !ack) |-> ##[1:2] ack_s)
    else $error("request not answered in two cycles");
  no_spur_a: assert property (ack_s |-> $past(req))
    else $error("answer without request");
  reset_quiet_a: assert property (disable iff (1'b0)
    rst_in |=> (!ack && !irq_out && terminal_out == 3'h0))
    else $error("outputs active after reset");
  unmapped_zero_a: assert property (
    (ack && bus_in.read && bus_in.address > `PPR_OFS_MV) |-> bus_out.readdata == 32'h0)
    else $error("unmapped read not zero");
  irq_idle_a: assert property ((!mask_reg && $past(!mask_reg)) |-> !irq_out)
    else $error("interrupt with mask clear");
  mode_idle_a: assert property (
    (st_rd && age_reg > 3 * PERIOD_CYC && !on) |-> !bus_out.readdata[3])
    else $error("regulation active in plain mode");
  mode_dir_a: assert property (
    (st_rd && age_reg > 3 * PERIOD_CYC && on) |-> bus_out.readdata[0] == mode_reg[0])
    else $error("action direction wrong");
endmodule // ppr_regulator_sva

bind ppr_regulator ppr_regulator_sva #(.PERIOD_CYC(PERIOD_CYC)) chk_u (
  .clk_in       (clk_in),
  .rst_in       (rst_in),
  .bus_in       (bus_in),
  .bus_out      (bus_out),
  .analog_in    (analog_in),
  .run_in       (run_in),
  .terminal_in  (terminal_in),
  .terminal_out (terminal_out),
  .irq_out      (irq_out)
);

// *** bench/ppr_detector.sv ***
// process detector and set point source on the analog inputs
// assumes 12-bit codes, set point 0 to 10V, measured 4 to 20mA
`timescale 1ns/10ps
`include "ppr_regs.svh"
module ppr_detector (
  input  wire logic                    clk_in,
  input  wire logic [9:0]              set_in,
  input  wire logic [9:0]              meas_in,
  input  wire logic                    fwd_in,
  output      ppr_pkg::ppr_analog_type analog_out,
  output      ppr_pkg::ppr_run_type    run_out
);
  import ppr_pkg::*;
  // ----
  // levels, tenths of a percent to codes
  // ----
  // combinational so the inputs have values from time zero
  assign analog_out.ain2 = 12'((32'(set_in) * 4095) / 1000);
  assign analog_out.ain4 = 12'(`PPR_ADC_4MA + (32'(meas_in) * 3276) / 1000);
  assign run_out = '{forward_rotation: fwd_in, reverse_rotation: !fwd_in};
endmodule // ppr_detector

// *** bench/ppr_regulator_tb.sv ***
// self-checking bench for the process pid regulator
// assumes regulator, checker and detector compiled before
`timescale 1ns/10ps
`include "ppr_regs.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module ppr_regulator_tb;
  import ppr_pkg::*;
  localparam int PER = 4;
  logic            clk_in;
  logic            rst_in;
  ppr_bus_req_type req;
  ppr_bus_rsp_type rsp;
  ppr_analog_type  ana;
  ppr_run_type     run;
  logic [6:0]      t_in;
  logic [2:0]      t_out;
  logic            irq;
  logic [9:0]      set_p;
  logic [9:0]      meas_p;
  logic            forward_rotation;
  logic [31:0]     q;
  int              bad_count;
  int              checked;
  ppr_regulator #(.PERIOD_CYC(PER)) dut_u (.clk_in(clk_in), .rst_in(rst_in), .bus_in(req),
    .bus_out(rsp), .analog_in(ana), .run_in(run), .terminal_in(t_in),
    .terminal_out(t_out), .irq_out(irq));
  ppr_detector det_u (.clk_in(clk_in), .set_in(set_p), .meas_in(meas_p), .fwd_in(forward_rotation),
    .analog_out(ana), .run_out(run));
  // ----
  // helpers
  // ----
  task automatic results();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    req <= '{read: !w, write: w, address: a, writedata: d};
    do begin
      @(posedge clk_in);
      n++;
    end while (rsp.waitrequest !== 1'b0 && n < 40);
    q = rsp.readdata;
    req <= '0;
    if (n >= 40) begin
      bad_count++;
      results();
    end
  endtask
  // waiting several periods lets the recompute land
  task automatic st();
    repeat (8 * PER) @(posedge clk_in);
    bus(0, `PPR_OFS_STATUS, 32'h0);
  endtask
  task automatic mv();
    st();
    bus(0, `PPR_OFS_MV, 32'h0);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_modes();
    logic [7:0] m[8] = '{8'd0, 8'd10, 8'd20, 8'd21, 8'd50, 8'd51, 8'd60, 8'd61};
    bus(1, `PPR_OFS_INFUNC, 32'h0);
    foreach (m[i]) begin
      bus(1, `PPR_OFS_MODE, {24'h0, m[i]});
      st();
      `CHK("active", logic'(m[i] inside {20, 21, 50, 51, 60, 61}), q[3])
      if (i > 1) `CHK("forward", m[i][0], q[0])
    end
  endtask
  task automatic t_select();
    bus(1, `PPR_OFS_MODE, 32'd20);
    bus(1, `PPR_OFS_INFUNC, 32'h0000_000E);
    st();
    `CHK("select off", 1'b0, q[3])
    t_in <= 7'h01;
    st();
    `CHK("select on", 1'b1, q[3])
    t_in <= 7'h00;
    bus(1, `PPR_OFS_CTRL, 32'h1);
    st();
    `CHK("network select", 1'b1, q[3])
    bus(1, `PPR_OFS_CTRL, 32'h0);
    bus(1, `PPR_OFS_INFUNC, 32'h0);
  endtask
  task automatic t_limits();
    bus(1, `PPR_OFS_MODE, 32'd60);
    bus(1, `PPR_OFS_UPLIM, 32'd700);
    bus(1, `PPR_OFS_LOLIM, 32'd300);
    bus(1, `PPR_OFS_NETMEAS, 32'd800);
    st();
    `CHK("upper", 2'b01, q[2:1])
    bus(1, `PPR_OFS_NETMEAS, 32'd200);
    st();
    `CHK("lower", 2'b10, q[2:1])
    bus(1, `PPR_OFS_MODE, 32'd50);
    st();
    `CHK("limit mode", 2'b00, q[2:1])
    bus(1, `PPR_OFS_MODE, 32'd60);
    bus(1, `PPR_OFS_UPLIM, 32'd9999);
    bus(1, `PPR_OFS_LOLIM, 32'd9999);
    st();
    `CHK("no limit", 2'b00, q[2:1])
  endtask
  task automatic t_action();
    bus(0, 8'h80, 32'h0);
    bus(1, `PPR_OFS_GAIN, 32'd100);
    bus(1, `PPR_OFS_INTEG, 32'd9999);
    bus(1, `PPR_OFS_DERIV, 32'd9999);
    bus(1, `PPR_OFS_NETSET, 32'd600);
    bus(1, `PPR_OFS_NETMEAS, 32'd400);
    mv();
    `CHK("mv reverse", 1'b1, $signed(q) > 0)
    bus(1, `PPR_OFS_MODE, 32'd61);
    mv();
    `CHK("mv forward", 1'b1, $signed(q) < 0)
    bus(1, `PPR_OFS_NETDEV, 32'h0001_FF38);
    bus(1, `PPR_OFS_MODE, 32'd50);
    mv();
    `CHK("mv network", 1'b1, $signed(q) < 0)
    bus(1, `PPR_OFS_SETPT, 32'd9999);
    bus(1, `PPR_OFS_MODE, 32'd20);
    set_p <= 10'd800;
    meas_p <= 10'd200;
    mv();
    `CHK("mv analog", 1'b1, $signed(q) > 0)
    bus(1, `PPR_OFS_SETPT, 32'd100);
    mv();
    `CHK("mv panel", 1'b1, $signed(q) < 0)
  endtask
  task automatic t_term_irq();
    bus(1, `PPR_OFS_MODE, 32'd0);
    bus(1, `PPR_OFS_OUTFUNC, 32'h0074_932F);
    bus(1, `PPR_OFS_IRQ_STAT, 32'hF);
    bus(1, `PPR_OFS_IRQ_MASK, 32'h2);
    forward_rotation <= 1'b1;
    st();
    `CHK("idle terms", 3'b010, t_out)
    `CHK("irq idle", 1'b0, irq)
    bus(1, `PPR_OFS_MODE, 32'd20);
    st();
    `CHK("active terms", 3'b001, t_out)
    `CHK("irq raised", 1'b1, irq)
    bus(1, `PPR_OFS_IRQ_STAT, 32'h2);
    st();
    `CHK("irq cleared", 1'b0, irq)
    forward_rotation <= 1'b0;
    st();
    `CHK("reverse terms", 3'b101, t_out)
    bus(1, `PPR_OFS_IRQ_MASK, 32'h0);
  endtask
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  initial begin
    rst_in = 1'b1;
    req = '0;
    t_in = 7'h00;
    set_p = 10'd500;
    meas_p = 10'd500;
    forward_rotation = 1'b0;
    bad_count = 0;
    checked = 0;
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    t_modes();
    t_select();
    t_limits();
    t_action();
    t_term_irq();
    results();
  end
endmodule // ppr_regulator_tb
